// ---- hw/cmc_pkg.sv ----
// Package of constants and types for the CAN mode-control block.
package cmc_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] CMC_ADDR_CTRL1   = 4'h0;
   localparam logic [3:0] CMC_ADDR_CFG2    = 4'h1;
   localparam logic [3:0] CMC_ADDR_STATUS  = 4'h2;
   localparam logic [3:0] CMC_ADDR_TXCTL   = 4'h3;
   localparam logic [3:0] CMC_ADDR_LOCKED  = 4'h4;
   // ----------------------------------------------------------------
   // Field positions of the mode control and CFG2 registers
   // ----------------------------------------------------------------
   localparam int CMC_BIT_STOP_IDLE  = 13;
   localparam int CMC_BIT_ABORT_ALL  = 12;
   localparam int CMC_POS_REQ        = 8;
   localparam int CMC_POS_OPM        = 5;
   localparam int CMC_BIT_CAPTURE    = 3;
   localparam int CMC_BIT_BANK       = 0;
   localparam int CMC_BIT_WAKE_LPF   = 14;
   // Status register bits.
   localparam int CMC_BIT_WAKE_FLAG  = 0;
   localparam int CMC_BIT_TX_ABORTED = 1;
   localparam int CMC_BIT_TX_REQUEST = 2;
   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [2:0]  CMC_RST_REQ     = 3'h4;
   localparam logic [2:0]  CMC_RST_OPM     = 3'h4;
   localparam logic [15:0] CMC_RST_LOCKED  = 16'h0000;
   localparam int          CMC_IDLE_BITS   = 11;
   localparam int          CMC_MAX_OVLD    = 2;
   // ----------------------------------------------------------------
   // Mode codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CMC_M_NORMAL  = 3'h0,
      CMC_M_DISABLE = 3'h1,
      CMC_M_LOOP    = 3'h2,
      CMC_M_LISTEN  = 3'h3,
      CMC_M_CONFIG  = 3'h4,
      CMC_M_RSV5    = 3'h5,
      CMC_M_RSV6    = 3'h6,
      CMC_M_LISTALL = 3'h7
   } cmc_mode_t;
   typedef enum logic [2:0] {
      CMC_S_STEADY  = 3'b001,
      CMC_S_WAIT    = 3'b010,
      CMC_S_ABORT   = 3'b100
   } cmc_state_t;
endpackage

// ---- hw/cmc_mode_ctrl.sv ----
// Operating-mode control for a CAN controller with register port and pin steering.
`timescale 1ns/1ps
`default_nettype none
module cmc_mode_ctrl
   import cmc_pkg::*;
#(
   parameter int TX_BUFS = 8
) (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic [3:0]         addr_i,
   input  wire logic [15:0]        wdata_i,
   input  wire logic               wr_i,
   input  wire logic               rd_i,
   output logic      [15:0]        rdata_o,
   input  wire logic               bit_tick_i,
   input  wire logic               bus_rx_i,
   input  wire logic               proto_tx_i,
   input  wire logic               proto_tx_busy_i,
   input  wire logic               tx_start_i,
   input  wire logic               msg_rx_done_i,
   input  wire logic               dev_idle_i,
   input  wire logic               dev_sleep_i,
   input  wire logic               remote_match_i,
   input  wire logic               overload_req_i,
   input  wire logic [TX_BUFS-1:0] tx_pending_i,
   output logic                    bus_tx_o,
   output logic                    bus_tx_oe_o,
   output logic                    rx_pin_owned_o,
   output logic                    proto_rx_o,
   output logic                    proto_run_o,
   output logic                    tx_allowed_o,
   output logic                    rx_allowed_o,
   output logic                    err_active_o,
   output logic                    err_cnt_clear_o,
   output logic                    ignore_errors_o,
   output logic                    wake_lpf_on_o,
   output logic [TX_BUFS-1:0]      tx_abort_o,
   output logic                    capture_o,
   output logic                    bank_filter_o,
   output logic                    overload_o,
   output logic                    auto_reply_o
);
   // ----------------------------------------------------------------
   // Receive pin synchroniser
   // ----------------------------------------------------------------
   logic [2:0] rx_sync_reg;
   logic       rx_level_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_sync_reg  <= 3'h7;
         rx_level_reg <= 1'b1;
      end else begin
         rx_sync_reg <= {rx_sync_reg[1:0], bus_rx_i};
         if (rx_sync_reg[2] == rx_sync_reg[1]) begin
            rx_level_reg <= rx_sync_reg[2];
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [2:0]  req_reg;
   logic [2:0]  opm_reg;
   logic        stop_idle_reg;
   logic        abort_all_reg;
   logic        capture_en_reg;
   logic        bank_reg;
   logic        wake_lpf_reg;
   logic        wake_flag_reg;
   logic        tx_aborted_reg;
   logic        tx_request_reg;
   logic [15:0] locked_reg;
   logic [3:0]  idle_cnt_reg;
   logic [1:0]  ovld_cnt_reg;
   logic        early_tx_reg;
   cmc_state_t  state_reg;
   cmc_state_t  state_next;

   wire in_config  = (opm_reg == CMC_M_CONFIG);
   wire in_disable = (opm_reg == CMC_M_DISABLE);
   wire in_normal  = (opm_reg == CMC_M_NORMAL);
   wire in_listen  = (opm_reg == CMC_M_LISTEN);
   wire in_loop    = (opm_reg == CMC_M_LOOP);
   wire in_listall = (opm_reg == CMC_M_LISTALL);
   wire bus_idle   = (idle_cnt_reg == 4'(CMC_IDLE_BITS));
   wire req_valid  = (req_reg != CMC_M_RSV5) && (req_reg != CMC_M_RSV6);
   wire want_chg   = req_valid && (req_reg != opm_reg);
   wire halted     = stop_idle_reg && dev_idle_i;
   wire tx_capable = in_normal || in_loop;

   wire wr_ctrl   = wr_i && (addr_i == CMC_ADDR_CTRL1);
   wire wr_cfg2   = wr_i && (addr_i == CMC_ADDR_CFG2);
   wire wr_status = wr_i && (addr_i == CMC_ADDR_STATUS);
   wire wr_txctl  = wr_i && (addr_i == CMC_ADDR_TXCTL);
   wire wr_locked = wr_i && (addr_i == CMC_ADDR_LOCKED);

   wire mode_ok  = bus_idle && !(req_reg == CMC_M_CONFIG && proto_tx_busy_i);
   wire early_ab = early_tx_reg && want_chg && (req_reg == CMC_M_DISABLE);

   // ----------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CMC_S_STEADY: begin
            if (early_ab) begin
               state_next = CMC_S_ABORT;
            end else if (want_chg) begin
               state_next = CMC_S_WAIT;
            end
         end
         CMC_S_WAIT: begin
            if (early_ab) begin
               state_next = CMC_S_ABORT;
            end else if (!want_chg || mode_ok) begin
               state_next = CMC_S_STEADY;
            end
         end
         CMC_S_ABORT: state_next = CMC_S_WAIT;
         default: state_next = CMC_S_STEADY;
      endcase
   end

   // Idle counter saturates so a long idle bus keeps the gate open.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_cnt_reg <= 4'h0;
      end else if (!rx_level_reg) begin
         idle_cnt_reg <= 4'h0;
      end else if (bit_tick_i && !bus_idle) begin
         idle_cnt_reg <= idle_cnt_reg + 4'h1;
      end
   end

   // Mode, control fields and flags.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg      <= CMC_S_STEADY;
         req_reg        <= CMC_RST_REQ;
         opm_reg        <= CMC_RST_OPM;
         stop_idle_reg  <= 1'b0;
         abort_all_reg  <= 1'b0;
         capture_en_reg <= 1'b0;
         bank_reg       <= 1'b0;
         wake_lpf_reg   <= 1'b0;
         locked_reg     <= CMC_RST_LOCKED;
      end else begin
         state_reg <= state_next;
         if (wr_ctrl) begin
            req_reg        <= wdata_i[CMC_POS_REQ +: 3];
            bank_reg       <= wdata_i[CMC_BIT_BANK];
         end
         if (wr_ctrl && in_config) begin
            stop_idle_reg  <= wdata_i[CMC_BIT_STOP_IDLE];
            capture_en_reg <= wdata_i[CMC_BIT_CAPTURE];
         end
         if (wr_cfg2 && in_config) begin
            wake_lpf_reg <= wdata_i[CMC_BIT_WAKE_LPF];
         end
         if (wr_locked && in_config) begin
            locked_reg <= wdata_i;
         end
         if (state_reg == CMC_S_WAIT && want_chg && mode_ok) begin
            opm_reg <= req_reg;
         end
         if (wr_ctrl && wdata_i[CMC_BIT_ABORT_ALL]) begin
            abort_all_reg <= 1'b1;
         end else if (tx_pending_i == '0) begin
            abort_all_reg <= 1'b0;
         end
      end
   end

   // Software clears the wake and tx-aborted status bits by writing one; a hardware set wins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_flag_reg  <= 1'b0;
         tx_aborted_reg <= 1'b0;
         tx_request_reg <= 1'b0;
         early_tx_reg   <= 1'b0;
      end else begin
         if (in_disable && !rx_level_reg) begin
            wake_flag_reg <= 1'b1;
         end else if (wr_status && wdata_i[CMC_BIT_WAKE_FLAG]) begin
            wake_flag_reg <= 1'b0;
         end
         if (state_reg == CMC_S_ABORT) begin
            tx_aborted_reg <= 1'b1;
            tx_request_reg <= 1'b0;
            early_tx_reg   <= 1'b0;
         end else begin
            if (wr_status && wdata_i[CMC_BIT_TX_ABORTED]) begin
               tx_aborted_reg <= 1'b0;
            end
            if (tx_start_i && tx_capable) begin
               tx_request_reg <= 1'b1;
               early_tx_reg   <= !bus_idle;
            end else if (wr_txctl && wdata_i[CMC_BIT_TX_REQUEST]) begin
               tx_request_reg <= 1'b1;
            end else if (proto_tx_busy_i) begin
               tx_request_reg <= 1'b0;
            end
            if (bus_idle || !tx_capable) begin
               early_tx_reg <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovld_cnt_reg <= 2'h0;
      end else if (overload_req_i && ovld_cnt_reg != 2'(CMC_MAX_OVLD)) begin
         ovld_cnt_reg <= ovld_cnt_reg + 2'h1;
      end else if (!overload_req_i) begin
         ovld_cnt_reg <= 2'h0;
      end
   end

   // ----------------------------------------------------------------
   // Pin steering and protocol permissions
   // ----------------------------------------------------------------
   // normal and listen-all modes own the transmit pin
   wire tx_pin_own = (in_normal || in_listall) && !halted;
   assign bus_tx_oe_o    = tx_pin_own;
   assign bus_tx_o       = tx_pin_own ? proto_tx_i : 1'b1;
   assign rx_pin_owned_o = (in_normal || in_listen || in_listall) && !halted;
   assign proto_rx_o     = in_loop ? proto_tx_i : rx_level_reg;
   assign proto_run_o    = !halted && !in_config && !in_disable;
   assign tx_allowed_o   = proto_run_o && (in_normal || in_loop || in_listall)
                           && !early_tx_reg;
   assign rx_allowed_o   = proto_run_o;
   assign err_cnt_clear_o = in_config;
   assign err_active_o    = proto_run_o && !in_listen && !in_listall;
   assign ignore_errors_o = in_listall;
   assign wake_lpf_on_o   = wake_lpf_reg && (in_disable || dev_sleep_i);
   assign tx_abort_o      = abort_all_reg ? tx_pending_i : '0;
   assign capture_o       = capture_en_reg && msg_rx_done_i && rx_allowed_o;
   assign bank_filter_o   = bank_reg;
   assign overload_o      = overload_req_i && ovld_cnt_reg != 2'(CMC_MAX_OVLD);
   assign auto_reply_o    = remote_match_i && tx_allowed_o;

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   wire [15:0] ctrl_word = {2'h0, stop_idle_reg, abort_all_reg, 1'b0, req_reg,
                            opm_reg, 1'b0, capture_en_reg, 2'h0, bank_reg};
   wire [15:0] rd_mux =
      (addr_i == CMC_ADDR_CTRL1)  ? ctrl_word :
      (addr_i == CMC_ADDR_CFG2)   ? {1'b0, wake_lpf_reg, 14'h0} :
      (addr_i == CMC_ADDR_STATUS) ? {13'h0, tx_request_reg, tx_aborted_reg,
                                     wake_flag_reg} :
      (addr_i == CMC_ADDR_TXCTL)  ? {15'h0, tx_request_reg} :
      (addr_i == CMC_ADDR_LOCKED) ? locked_reg : 16'h0000;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
      end else begin
         rdata_o <= rd_i ? rd_mux : 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_mode_gate;
      @(posedge clk_i) disable iff (rst_i)
      !$stable(opm_reg) |-> $past(bus_idle);
   endproperty
   a_mode_gate: assert property (p_mode_gate) else $error("mode changed on busy bus");
   property p_no_cfg_tx;
      @(posedge clk_i) disable iff (rst_i)
      (opm_reg == CMC_M_CONFIG) && $changed(opm_reg) |-> !$past(proto_tx_busy_i);
   endproperty
   a_no_cfg_tx: assert property (p_no_cfg_tx) else $error("config entered in tx");
   property p_cfg_quiet;
      @(posedge clk_i) disable iff (rst_i)
      in_config |-> !tx_allowed_o && !rx_allowed_o && err_cnt_clear_o;
   endproperty
   a_cfg_quiet: assert property (p_cfg_quiet) else $error("config not quiet");
   property p_lock;
      @(posedge clk_i) disable iff (rst_i)
      !in_config ##1 1'b1 |-> $stable(capture_en_reg) && $stable(stop_idle_reg)
                              && $stable(wake_lpf_reg) && $stable(locked_reg);
   endproperty
   a_lock: assert property (p_lock) else $error("locked register changed");
   property p_disable_pins;
      @(posedge clk_i) disable iff (rst_i)
      in_disable || in_loop |-> !bus_tx_oe_o && !rx_pin_owned_o;
   endproperty
   a_disable_pins: assert property (p_disable_pins) else $error("pins not released");
   property p_listen;
      @(posedge clk_i) disable iff (rst_i)
      in_listen |-> !bus_tx_oe_o && !err_active_o;
   endproperty
   a_listen: assert property (p_listen) else $error("listen not passive");
   property p_loop;
      @(posedge clk_i) disable iff (rst_i)
      in_loop |-> proto_rx_o == proto_tx_i;
   endproperty
   a_loop: assert property (p_loop) else $error("loopback path broken");
   property p_early_abort;
      @(posedge clk_i) disable iff (rst_i)
      early_ab |-> ##3 tx_aborted_reg && !tx_request_reg;
   endproperty
   a_early_abort: assert property (p_early_abort) else $error("early abort missing");
   property p_ovld;
      @(posedge clk_i) disable iff (rst_i)
      overload_o [*2] |=> !overload_o;
   endproperty
   a_ovld: assert property (p_ovld) else $error("third overload frame");
endmodule
`default_nettype wire

// ---- testbench/cmc_bus_node.sv ----
// Behavioural model of the other nodes on the CAN bus, wired-AND with the block's driver.
`timescale 1ns/1ps
`default_nettype none
module cmc_bus_node #(
   parameter int BIT_CLKS = 4
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic busy_i,
   input  wire logic tx_i,
   input  wire logic tx_oe_i,
   output logic      bit_tick_o,
   output logic      rx_o
);
   int   div_reg;
   logic node_bit_reg;
   // ----------------------------------------------------------------
   // Bit timing and traffic
   // ----------------------------------------------------------------
   // While busy the other nodes toggle every bit, so the bus never shows an idle run.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_reg      <= 0;
         node_bit_reg <= 1'b1;
         bit_tick_o   <= 1'b0;
      end else begin
         bit_tick_o <= (div_reg == BIT_CLKS - 1);
         div_reg    <= (div_reg == BIT_CLKS - 1) ? 0 : div_reg + 1;
         if (div_reg == BIT_CLKS - 1) begin
            node_bit_reg <= busy_i ? ~node_bit_reg : 1'b1;
         end
      end
   end
   // ----------------------------------------------------------------
   // Bus level
   // ----------------------------------------------------------------
   // A dominant level from either side wins; a released driver leaves the recessive level.
   assign rx_o = node_bit_reg & (tx_i | ~tx_oe_i);
endmodule
`default_nettype wire

// ---- testbench/cmc_mode_ctrl_test.sv ----
// Self-checking testbench for the CAN mode-control block.
`timescale 1ns/1ps
`default_nettype none
module cmc_mode_ctrl_test;
   import cmc_pkg::*;
   logic        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic [3:0]  addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000, rdata_o, ctrl_sh;
   logic        bit_tick_i, bus_rx_i, proto_tx_i = 1'b1, proto_tx_busy_i = 1'b0;
   logic        tx_start_i = 1'b0, msg_rx_done_i = 1'b0, dev_idle_i = 1'b0;
   logic        dev_sleep_i = 1'b0, remote_match_i = 1'b0, overload_req_i = 1'b0;
   logic [7:0]  tx_pending_i = 8'h00, tx_abort_o;
   logic        bus_tx_o, bus_tx_oe_o, rx_pin_owned_o, proto_rx_o, proto_run_o;
   logic        tx_allowed_o, rx_allowed_o, err_active_o, err_cnt_clear_o;
   logic        ignore_errors_o, wake_lpf_on_o, capture_o, bank_filter_o;
   logic        overload_o, auto_reply_o, bus_busy = 1'b0;
   logic [2:0]  prev, m;
   logic [2:0]  seq [5] = '{CMC_M_NORMAL, CMC_M_LISTEN, CMC_M_LISTALL, CMC_M_LOOP, CMC_M_DISABLE};
   int          err_count = 0, comparisons = 0, hits;
   always #12.5 clk_i = ~clk_i;
   cmc_mode_ctrl #(.TX_BUFS(8)) cmc_mode_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .bit_tick_i(bit_tick_i), .bus_rx_i(bus_rx_i), .proto_tx_i(proto_tx_i),
      .proto_tx_busy_i(proto_tx_busy_i), .tx_start_i(tx_start_i),
      .msg_rx_done_i(msg_rx_done_i), .dev_idle_i(dev_idle_i), .dev_sleep_i(dev_sleep_i),
      .remote_match_i(remote_match_i), .overload_req_i(overload_req_i),
      .tx_pending_i(tx_pending_i), .bus_tx_o(bus_tx_o), .bus_tx_oe_o(bus_tx_oe_o),
      .rx_pin_owned_o(rx_pin_owned_o), .proto_rx_o(proto_rx_o), .proto_run_o(proto_run_o),
      .tx_allowed_o(tx_allowed_o), .rx_allowed_o(rx_allowed_o), .err_active_o(err_active_o),
      .err_cnt_clear_o(err_cnt_clear_o), .ignore_errors_o(ignore_errors_o),
      .wake_lpf_on_o(wake_lpf_on_o), .tx_abort_o(tx_abort_o), .capture_o(capture_o),
      .bank_filter_o(bank_filter_o), .overload_o(overload_o), .auto_reply_o(auto_reply_o));
   cmc_bus_node #(.BIT_CLKS(4)) cmc_bus_node_inst (.clk_i(clk_i), .rst_i(rst_i),
      .busy_i(bus_busy), .tx_i(bus_tx_o), .tx_oe_i(bus_tx_oe_o),
      .bit_tick_o(bit_tick_i), .rx_o(bus_rx_i));
   // ----------------------------------------------------------------
   // Access and comparison tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
   task automatic rdc(input logic [3:0] a, input logic [15:0] mask, input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o & mask, exp);
   endtask
   task automatic wait_mode(input logic [2:0] want);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         addr_i <= CMC_ADDR_CTRL1;
         rd_i   <= 1'b1;
         @(posedge clk_i);
         rd_i <= 1'b0;
         #1 n++;
      end while (rdata_o[7:5] !== want && n < 80);
      chk({13'h0, rdata_o[7:5]}, {13'h0, want});
      if (rdata_o[7:5] !== want) report_and_stop();
   endtask
   task automatic mode_pins(input logic [2:0] md);
      case (md)
         CMC_M_NORMAL: chk({11'h0, bus_tx_o, bus_tx_oe_o, rx_pin_owned_o, tx_allowed_o,
                           rx_allowed_o}, 16'h001f);
         CMC_M_DISABLE: chk({12'h0, bus_tx_oe_o, rx_pin_owned_o, tx_allowed_o, rx_allowed_o},
                            16'h0000);
         CMC_M_LISTEN: chk({12'h0, bus_tx_oe_o, err_active_o, tx_allowed_o, rx_allowed_o},
                           16'h0001);
         CMC_M_LISTALL: chk({14'h0, ignore_errors_o, rx_allowed_o}, 16'h0003);
         CMC_M_CONFIG: chk({13'h0, tx_allowed_o, rx_allowed_o, err_cnt_clear_o},
                           16'h0001);
         default: begin
            chk({15'h0, bus_tx_oe_o}, 16'h0000);
            @(posedge clk_i);
            proto_tx_i <= 1'b0;
            @(posedge clk_i);
            #1 chk({15'h0, proto_rx_o}, 16'h0000);
            proto_tx_i <= 1'b1;
            @(posedge clk_i);
            #1 chk({15'h0, proto_rx_o}, 16'h0001);
         end
      endcase
   endtask
   task automatic normal_extras;
      wr(CMC_ADDR_CFG2, 16'h0000);
      rdc(CMC_ADDR_CFG2, 16'h4000, 16'h4000);
      wr(CMC_ADDR_CTRL1, ctrl_sh & 16'hfff7);
      rdc(CMC_ADDR_CTRL1, 16'h0008, 16'h0008);
      wr(CMC_ADDR_LOCKED, 16'h1234);
      rdc(CMC_ADDR_LOCKED, 16'hffff, 16'h5a5a);
      hits = 0;
      @(posedge clk_i);
      msg_rx_done_i <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         #1 hits = hits + int'(capture_o);
         @(posedge clk_i);
         msg_rx_done_i <= 1'b0;
      end
      chk(16'(hits), 16'h0001);
      hits = 0;
      overload_req_i <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         #1 hits = hits + int'(overload_o);
         @(posedge clk_i);
      end
      overload_req_i <= 1'b0;
      chk(16'(hits), 16'h0002);
      remote_match_i <= 1'b1;
      @(posedge clk_i);
      #1 chk({14'h0, auto_reply_o, proto_run_o}, 16'h0003);
      dev_idle_i <= 1'b1;
      @(posedge clk_i);
      #1 chk({14'h0, auto_reply_o, proto_run_o}, 16'h0000);
      remote_match_i <= 1'b0;
      dev_idle_i     <= 1'b0;
      @(posedge clk_i);
      #1 chk({14'h0, auto_reply_o, proto_run_o}, 16'h0001);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(CMC_ADDR_CTRL1, 16'hffff, 16'h0480);
      rdc(CMC_ADDR_STATUS, 16'hffff, 16'h0000);
      rdc(4'hf, 16'hffff, 16'h0000);
      mode_pins(CMC_M_CONFIG);
      ctrl_sh = 16'h2409;
      wr(CMC_ADDR_CFG2, 16'h4000);
      wr(CMC_ADDR_CTRL1, ctrl_sh);
      rdc(CMC_ADDR_CTRL1, 16'hffff, 16'h2489);
      rdc(CMC_ADDR_CFG2, 16'h4000, 16'h4000);
      wr(CMC_ADDR_LOCKED, 16'h5a5a);
      rdc(CMC_ADDR_LOCKED, 16'hffff, 16'h5a5a);
      dev_sleep_i <= 1'b1;
      @(posedge clk_i);
      #1 chk({14'h0, wake_lpf_on_o, bank_filter_o}, 16'h0003);
      dev_sleep_i <= 1'b0;
      $display("test configuration done");
      prev = CMC_M_CONFIG;
      foreach (seq[i]) begin
         m = seq[i];
         bus_busy <= 1'b1;
         // Let the traffic reach the idle counter first, or a long idle run lets the change through.
         repeat (12) @(posedge clk_i);
         if (m == CMC_M_DISABLE) begin
            wr(CMC_ADDR_TXCTL, 16'h0001);
            @(posedge clk_i);
            tx_start_i <= 1'b1;
            @(posedge clk_i);
            tx_start_i <= 1'b0;
         end
         ctrl_sh[10:8] = m;
         wr(CMC_ADDR_CTRL1, ctrl_sh);
         repeat (30) @(posedge clk_i);
         rdc(CMC_ADDR_CTRL1, 16'h00e0, {8'h00, prev, 5'h00});
         if (m == CMC_M_DISABLE) rdc(CMC_ADDR_STATUS, 16'h0006, 16'h0002);
         bus_busy <= 1'b0;
         wait_mode(m);
         mode_pins(m);
         if (m == CMC_M_NORMAL) normal_extras();
         prev = m;
         $display("test mode %0d done", m);
      end
      wr(CMC_ADDR_STATUS, 16'h0007);
      bus_busy <= 1'b1;
      repeat (20) @(posedge clk_i);
      rdc(CMC_ADDR_STATUS, 16'h0001, 16'h0001);
      bus_busy        <= 1'b0;
      proto_tx_busy_i <= 1'b1;
      ctrl_sh[10:8] = CMC_M_CONFIG;
      wr(CMC_ADDR_CTRL1, ctrl_sh);
      repeat (100) @(posedge clk_i);
      rdc(CMC_ADDR_CTRL1, 16'h00e0, 16'h0020);
      proto_tx_busy_i <= 1'b0;
      wait_mode(CMC_M_CONFIG);
      $display("test wake and configuration entry done");
      wr(CMC_ADDR_CTRL1, ctrl_sh | 16'h0100);
      repeat (100) @(posedge clk_i);
      rdc(CMC_ADDR_CTRL1, 16'h00e0, 16'h0080);
      tx_pending_i <= 8'h0f;
      wr(CMC_ADDR_CTRL1, ctrl_sh | 16'h1000);
      #1 chk({8'h00, tx_abort_o}, 16'h000f);
      rdc(CMC_ADDR_CTRL1, 16'h1000, 16'h1000);
      tx_pending_i <= 8'h00;
      repeat (3) @(posedge clk_i);
      rdc(CMC_ADDR_CTRL1, 16'h1000, 16'h0000);
      $display("test reserved code and abort done");
      report_and_stop();
   end
endmodule
`default_nettype wire
